// *** pad_pkg.sv ***
// Package for the pad-state and media pair mapping block.
// Assumes one core clock; all mode inputs arrive from pins or core logic.
// Operation
// - Media pair drivers active in loopback, high impedance in any reset or power down.
// - Serial MAC output rests on its 50 ohm terminations in software or hardware reset.
// - In power down the serial output follows config bit 3: 0 rests, 1 active.
// - Management data pin active except while hardware reset is asserted.
// - Interrupt output normal in loopback, released in resets and power down.
// - Test data output stays active in every condition.
// - Gigabit straight: media pairs 0..3 go to pairs A, B, C, D.
// - Gigabit crossover: media pairs 0..3 go to pairs B, A, D, C.
// - 10/100 straight: transmit on media pair 0, receive on pair 1.
// - 10/100 crossover: receive on media pair 0, transmit on pair 1.
// - 10/100 leaves media pairs 2 and 3 unused.
package pad_pkg;
	localparam int NUM_PAIRS = 4;
	localparam int CFG_SERIAL_KEEP_BIT = 3;
	localparam logic [1:0] PAIR_A = 2'h0;
	localparam logic [1:0] PAIR_B = 2'h1;
	localparam logic [1:0] PAIR_C = 2'h2;
	localparam logic [1:0] PAIR_D = 2'h3;
	localparam logic [1:0] SPEED_10 = 2'h0;
	localparam logic [1:0] SPEED_100 = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	typedef enum logic [4:0] {
		ST_NORMAL = 5'b00001,
		ST_LOOPBACK = 5'b00010,
		ST_POWER_DOWN = 5'b00100,
		ST_SOFT_RESET = 5'b01000,
		ST_HARD_RESET = 5'b10000
	} pad_state_t;

	typedef struct packed {
		logic hard_reset;
		logic soft_reset;
		logic power_down;
		logic loopback;
	} pad_cond_t;

	typedef struct packed {
		logic [3:0] pair_oe_n;
		logic serial_active;
		logic mgmt_oe_n;
		logic irq_oe_n;
		logic tdo_oe_n;
	} pad_ctl_t;

	// Per media pair: IEEE letter, gigabit use, 10/100 tx and rx role
	typedef struct packed {
		logic [1:0] letter;
		logic tx;
		logic rx;
	} pair_route_t;
endpackage

// *** pair_route.sv ***
// One media pair's route to an IEEE pair letter and 10/100 role.
// Assumes speed and crossover are already synchronised.
`timescale 1ns/10ps
`default_nettype none
module pair_route #(
	parameter int PAIR = 0
) (
	// Mode
	input wire logic [1:0] speed,
	input wire logic crossover,
	// Route
	output var pad_pkg::pair_route_t route
);
	localparam logic [1:0] IDX = 2'(PAIR);

	always_comb begin
		route = '0;
		if (speed == pad_pkg::SPEED_1000) begin
			route.tx = 1'b1;
			route.rx = 1'b1;
			if (crossover) begin
				route.letter = IDX ^ 2'h1;
			end else begin
				route.letter = IDX;
			end
		end else if (IDX == 2'h0) begin
			route.letter = pad_pkg::PAIR_A;
			route.tx = !crossover;
			route.rx = crossover;
		end else if (IDX == 2'h1) begin
			route.letter = pad_pkg::PAIR_B;
			route.tx = crossover;
			route.rx = !crossover;
		end else begin
			route.letter = IDX;
		end
	end
endmodule
`default_nettype wire

// *** pad_state_ctl.sv ***
// Pad-state selection and media pair mapping for one port.
// Assumes mode bits come from pins or another domain and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
module pad_state_ctl (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Conditions and configuration
	input wire pad_pkg::pad_cond_t cond,
	input wire logic [15:0] cfg,
	input wire logic [1:0] speed,
	input wire logic crossover,
	// Pad controls
	output var pad_pkg::pad_ctl_t ctl_r,
	output var pad_pkg::pad_state_t state_r,
	output var pad_pkg::pair_route_t [3:0] route_r
);
	pad_pkg::pad_cond_t cond_s1_r, cond_s2_r;
	logic [15:0] cfg_s1_r, cfg_s2_r;
	logic [1:0] spd_s1_r, spd_s2_r;
	logic xo_s1_r, xo_s2_r;
	pad_pkg::pad_state_t state_nxt;
	pad_pkg::pad_ctl_t ctl_nxt;
	pad_pkg::pair_route_t [3:0] route_nxt;

	// Two-stage synchronisers; first stage read only by second
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cond_s1_r <= '0;
			cond_s2_r <= '0;
			cfg_s1_r <= pad_pkg::CFG_RESET;
			cfg_s2_r <= pad_pkg::CFG_RESET;
			spd_s1_r <= pad_pkg::SPEED_10;
			spd_s2_r <= pad_pkg::SPEED_10;
			xo_s1_r <= 1'b0;
			xo_s2_r <= 1'b0;
		end else begin
			cond_s1_r <= cond;
			cond_s2_r <= cond_s1_r;
			cfg_s1_r <= cfg;
			cfg_s2_r <= cfg_s1_r;
			spd_s1_r <= speed;
			spd_s2_r <= spd_s1_r;
			xo_s1_r <= crossover;
			xo_s2_r <= xo_s1_r;
		end
	end

	// Precedence is fixed so overlapping conditions give one pad state
	always_comb begin
		if (cond_s2_r.hard_reset) begin
			state_nxt = pad_pkg::ST_HARD_RESET;
		end else if (cond_s2_r.soft_reset) begin
			state_nxt = pad_pkg::ST_SOFT_RESET;
		end else if (cond_s2_r.power_down) begin
			state_nxt = pad_pkg::ST_POWER_DOWN;
		end else if (cond_s2_r.loopback) begin
			state_nxt = pad_pkg::ST_LOOPBACK;
		end else begin
			state_nxt = pad_pkg::ST_NORMAL;
		end
	end

	// Enables are active low: 0 means the pad drives
	always_comb begin
		ctl_nxt.tdo_oe_n = 1'b0;
		case (state_nxt)
			pad_pkg::ST_HARD_RESET: begin
				ctl_nxt.pair_oe_n = 4'hF;
				ctl_nxt.serial_active = 1'b0;
				ctl_nxt.mgmt_oe_n = 1'b1;
				ctl_nxt.irq_oe_n = 1'b1;
			end
			pad_pkg::ST_SOFT_RESET: begin
				ctl_nxt.pair_oe_n = 4'hF;
				ctl_nxt.serial_active = 1'b0;
				ctl_nxt.mgmt_oe_n = 1'b0;
				ctl_nxt.irq_oe_n = 1'b1;
			end
			pad_pkg::ST_POWER_DOWN: begin
				ctl_nxt.pair_oe_n = 4'hF;
				ctl_nxt.serial_active = cfg_s2_r[pad_pkg::CFG_SERIAL_KEEP_BIT];
				ctl_nxt.mgmt_oe_n = 1'b0;
				ctl_nxt.irq_oe_n = 1'b1;
			end
			pad_pkg::ST_LOOPBACK, pad_pkg::ST_NORMAL: begin
				ctl_nxt.pair_oe_n = 4'h0;
				ctl_nxt.serial_active = 1'b1;
				ctl_nxt.mgmt_oe_n = 1'b0;
				ctl_nxt.irq_oe_n = 1'b0;
			end
			default: begin
				ctl_nxt.pair_oe_n = 4'hF;
				ctl_nxt.serial_active = 1'b0;
				ctl_nxt.mgmt_oe_n = 1'b1;
				ctl_nxt.irq_oe_n = 1'b1;
			end
		endcase
	end

	for (genvar i = 0; i < pad_pkg::NUM_PAIRS; i++) begin : g_pair
		pair_route #(
			.PAIR(i)
		) u_route (
			.speed(spd_s2_r),
			.crossover(xo_s2_r),
			.route(route_nxt[i])
		);
	end

	// Reset state matches hardware reset pad behaviour
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= pad_pkg::ST_HARD_RESET;
			ctl_r <= '{pair_oe_n: 4'hF, serial_active: 1'b0, mgmt_oe_n: 1'b1,
				irq_oe_n: 1'b1, tdo_oe_n: 1'b0};
			route_r <= '0;
		end else begin
			state_r <= state_nxt;
			ctl_r <= ctl_nxt;
			route_r <= route_nxt;
		end
	end
endmodule
`default_nettype wire

// *** pad_props.sv ***
// Checker for the pad-state block, bound to its ports.
// Assumes three edges from any input to the outputs.
`timescale 1ns/10ps
`default_nettype none
module pad_props (
	// Inputs
	input wire logic clock,
	input wire logic rst,
	input wire pad_pkg::pad_cond_t cond,
	input wire logic [15:0] cfg,
	input wire logic [1:0] speed,
	input wire logic crossover,
	// Outputs
	input wire pad_pkg::pad_ctl_t ctl_r,
	input wire pad_pkg::pad_state_t state_r,
	input wire pad_pkg::pair_route_t [3:0] route_r
);
	logic [1:0] age_r;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// $past looks into reset until the sync pipe refills
	always_ff @(posedge clock or posedge rst)
		if (rst) age_r <= 2'h0;
		else if (age_r != 2'h3) age_r <= age_r + 2'h1;
	a_hard_wins: assert property (&age_r && $past(cond.hard_reset, 3) |-> state_r[4])
		else $error("hard reset lost");
	a_pairs_off: assert property (ctl_r.pair_oe_n == {4{|state_r[4:2]}})
		else $error("pair enable wrong");
	a_serial_rest: assert property (|state_r[4:3] |-> !ctl_r.serial_active)
		else $error("serial not resting");
	a_serial_pd: assert property (&age_r && state_r[2] |-> ctl_r.serial_active == $past(cfg[3], 3))
		else $error("serial ignores config");
	a_mgmt_hiz: assert property (ctl_r.mgmt_oe_n == state_r[4])
		else $error("mgmt enable wrong");
	a_irq_off: assert property (ctl_r.irq_oe_n == |state_r[4:2])
		else $error("irq enable wrong");
	a_gig_map: assert property (&age_r && $past(speed, 3) == pad_pkg::SPEED_1000
		|-> route_r == ($past(crossover, 3) ? 16'hbf37 : 16'hfb73)) else $error("gig map");
	a_slow_map: assert property (&age_r && $past(speed, 3) != pad_pkg::SPEED_1000
		|-> (route_r & 16'h3333) == ($past(crossover, 3) ? 16'h0021 : 16'h0012))
		else $error("slow map");
	cover property (state_r[2] && ctl_r.serial_active);
	cover property (state_r[1]);
	cover property (route_r == 16'hbf37);
endmodule
bind pad_state_ctl pad_props props (.*);
`default_nettype wire

// *** link_partner.sv ***
// Cable partner: hears the pairs the block drives to transmit.
// Assumes pad enables and routes straight from the block.
`timescale 1ns/10ps
`default_nettype none
module link_partner (
	// Block side
	input wire logic [3:0] pair_oe_n,
	input wire pad_pkg::pair_route_t [3:0] route,
	output logic [3:0] heard
);
	always_comb for (int i = 0; i < 4; i++) heard[i] = !pair_oe_n[i] && route[i].tx;
endmodule
`default_nettype wire

// *** pad_state_ctl_tb.sv ***
// Testbench for the pad-state block with a cable partner.
// Assumes outputs settle three edges after inputs.
`timescale 1ns/10ps
`default_nettype none
module pad_state_ctl_tb;
	logic clock = 1'b0, rst = 1'b1, crossover = 1'b0;
	pad_pkg::pad_cond_t cond = '0;
	logic [15:0] cfg = '0;
	logic [1:0] speed = '0;
	pad_pkg::pad_ctl_t ctl_r;
	pad_pkg::pad_state_t state_r;
	pad_pkg::pair_route_t [3:0] route_r;
	logic [3:0] heard;
	int num_errors = 0, compares = 0, cycles = 0;
	pad_state_ctl dut (
		.clock(clock),
		.rst(rst),
		.cond(cond),
		.cfg(cfg),
		.speed(speed),
		.crossover(crossover),
		.ctl_r(ctl_r),
		.state_r(state_r),
		.route_r(route_r)
	);
	link_partner far (.pair_oe_n(ctl_r.pair_oe_n), .route(route_r), .heard(heard));
	always #2 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 1000) begin
			num_errors++;
			stop_test;
		end
	end
	task stop_test;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task settle(input logic [3:0] c, input logic [15:0] g, input logic [1:0] s, input logic x);
		@(posedge clock);
		cond <= c;
		cfg <= g;
		speed <= s;
		crossover <= x;
		repeat (4) @(posedge clock);
		#1;
	endtask
	task t_reset;
		check({3'h0, state_r, ctl_r}, 16'h10f6);
		$display("reset done");
	endtask
	// Loopback, power down twice, soft, hard, then overlaps and idle
	task t_pads;
		logic [31:0] c = 32'h0f78_4221;
		logic [15:0] e [8] = '{16'h0208, 16'h04f2, 16'h04fa, 16'h08f2,
			16'h10f6, 16'h08f2, 16'h10f6, 16'h0108};
		for (int i = 0; i < 8; i++) begin
			settle(c[i*4+:4], i > 1 ? 16'h0008 : 16'h0000, 2'h2, 1'b0);
			check({3'h0, state_r, ctl_r}, e[i]);
		end
		$display("pads done");
	endtask
	task t_route;
		logic [1:0] s;
		logic x;
		logic [15:0] e, m;
		for (int i = 0; i < 8; i++) begin
			s = i[2:1];
			x = i[0];
			settle(4'h0, 16'h0000, s, x);
			e = s == 2'h2 ? (x ? 16'hbf37 : 16'hfb73) : (x ? 16'h0021 : 16'h0012);
			m = s == 2'h2 ? 16'hffff : 16'h3333;
			check(16'(route_r) & m, e);
			check({12'h0, heard}, s == 2'h2 ? 16'h000f : {14'h0, x, !x});
		end
		$display("route done");
	endtask
	// Reset pulse in mid-run must drop pads at once, then recover
	task t_midreset;
		settle(4'h1, 16'h0000, 2'h2, 1'b1);
		@(posedge clock);
		rst <= 1'b1;
		@(posedge clock);
		rst <= 1'b0;
		#1;
		check({3'h0, state_r, ctl_r}, 16'h10f6);
		check(16'(route_r), 16'h0000);
		repeat (4) @(posedge clock);
		#1;
		check({3'h0, state_r, ctl_r}, 16'h0208);
		check(16'(route_r), 16'hbf37);
		$display("midreset done");
	endtask
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		#1;
		t_reset;
		t_pads;
		t_route;
		t_midreset;
		stop_test;
	end
endmodule
`default_nettype wire
